// *** logic/eprom_word_access.sv ***
// EPROM word access controller with APB register slave
// Behaviour
// - pointer-high bit 7 picks mode: 0 OTP read, 1 built-in EPROM.
// - EPROM mode write with pointer above 3FH is ignored.
// - completed EPROM write increments low pointer, saturating at 3FH.
// - programming-voltage status bit mirrors supply presence; software cannot change it.
// - setting write bit requests a word write; zero means no write.
// - setting read bit loads addressed word into data registers.
// - EPROM word address is the six-bit low pointer field, 64 words.
// - OTP address is pointer-high bits 2:0 over full low pointer byte.
// - word bits 15:8 in data high, 7:0 in data low.
// - write bit clears itself when the write finishes.
// - read bit clears itself once read data sits in data registers.
// - write ignored when supply status is 0 or pointer above 3FH.
// - completed read also increments low pointer, saturating at 3FH.
`timescale 1ns/1ps
module eprom_word_access
    import eprom_word_access_pkg::*;
#(
    parameter int WRITE_CNT = eprom_word_access_pkg::WRITE_CYCLES
) (
    input  wire logic                                  sys_clk,
    input  wire logic                                  rstn,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [eprom_word_access_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                           pwdata,
    output logic      [31:0]                           prdata,
    output logic                                       pready,
    output logic                                       pslverr,
    input  wire logic                                  vpp_present,
    output logic      [5:0]                            eprom_addr,
    output logic      [15:0]                           eprom_wdata,
    output logic                                       eprom_we,
    output logic                                       eprom_re,
    input  wire logic [15:0]                           eprom_rdata,
    output logic      [10:0]                           otp_addr,
    output logic                                       otp_re,
    input  wire logic [15:0]                           otp_rdata
);
    import eprom_word_access_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0]   ptr_high_r;
    logic [7:0]   ptr_low_r;
    logic [7:0]   data_high_r;
    logic [7:0]   data_low_r;
    logic         write_cmd_r;
    logic         read_cmd_r;
    op_state_t    state_r;
    logic [CNT_W-1:0] cnt_r;

    logic [9:0]   idx;
    logic         idx_ok;
    logic         sel_ctl, sel_ph, sel_pl, sel_dh, sel_dl;
    logic         wr_acc;
    logic         mode_eprom;
    logic         busy;
    logic         start_wr;
    logic         start_rd;
    logic         op_done;
    logic [7:0]   ptr_inc;

    ////////////////////////////////////////////////////////////////////////
    // APB decode: both register banks alias the same storage
    assign idx     = paddr[ADDR_W-1:2];
    assign sel_ctl = (idx == IDX_CONTROL)      || (idx == IDX_CONTROL_ALT);
    assign sel_ph  = (idx == IDX_POINTER_HIGH) || (idx == IDX_POINTER_HIGH_ALT);
    assign sel_pl  = (idx == IDX_POINTER_LOW)  || (idx == IDX_POINTER_LOW_ALT);
    assign sel_dh  = (idx == IDX_DATA_HIGH)    || (idx == IDX_DATA_HIGH_ALT);
    assign sel_dl  = (idx == IDX_DATA_LOW)     || (idx == IDX_DATA_LOW_ALT);
    assign idx_ok  = sel_ctl | sel_ph | sel_pl | sel_dh | sel_dl;
    assign pready  = 1'b1;                       // Zero wait states
    assign pslverr = psel & penable & ~idx_ok;   // Unmapped word errors
    assign wr_acc  = psel & penable & pwrite & idx_ok;

    // Read mux, registered only at the access phase by the master
    always_comb begin
        prdata = 32'h0000_0000;
        if (sel_ctl) begin
            prdata[BIT_VPP]   = vpp_present;
            prdata[BIT_WRITE] = write_cmd_r;
            prdata[BIT_READ]  = read_cmd_r;
        end else if (sel_ph) begin
            prdata[7:0] = ptr_high_r;
        end else if (sel_pl) begin
            prdata[7:0] = ptr_low_r;
        end else if (sel_dh) begin
            prdata[7:0] = data_high_r;
        end else if (sel_dl) begin
            prdata[7:0] = data_low_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command acceptance
    assign mode_eprom = ptr_high_r[BIT_MODE];
    assign busy       = (state_r != ST_IDLE);
    // Writes only exist in EPROM mode, need supply and an in-range pointer
    assign start_wr = wr_acc && sel_ctl && pwdata[BIT_WRITE] && !busy && mode_eprom
                      && vpp_present && (ptr_low_r <= MAX_POINTER);
    assign start_rd = wr_acc && sel_ctl && pwdata[BIT_READ] && !busy
                      && !start_wr;
    assign op_done  = busy && (cnt_r == '0);
    // Saturating step; pointer above range is pulled back to the top word
    assign ptr_inc  = (ptr_low_r >= MAX_POINTER) ? MAX_POINTER
                                                 : ptr_low_r + 8'h01;

    ////////////////////////////////////////////////////////////////////////
    // Operation sequencer
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            cnt_r   <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (start_wr) begin
                        state_r <= ST_WRITE;
                        cnt_r   <= CNT_W'(WRITE_CNT - 1);
                    end else if (start_rd) begin
                        state_r <= ST_READ;
                        cnt_r   <= CNT_W'(READ_CYCLES - 1);
                    end
                end
                ST_READ, ST_WRITE: begin
                    if (op_done) begin
                        state_r <= ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Command bits: set on accept, cleared by completion
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            write_cmd_r <= 1'b0;
            read_cmd_r  <= 1'b0;
        end else begin
            if (start_wr) begin
                write_cmd_r <= 1'b1;
            end else if (op_done && state_r == ST_WRITE) begin
                write_cmd_r <= 1'b0;
            end
            if (start_rd) begin
                read_cmd_r <= 1'b1;
            end else if (op_done && state_r == ST_READ) begin
                read_cmd_r <= 1'b0;
            end
        end
    end

    // Pointer registers: software writes blocked while busy
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ptr_high_r <= RST_BYTE;
            ptr_low_r  <= RST_BYTE;
        end else begin
            if (op_done) begin
                ptr_low_r <= ptr_inc;
            end else if (wr_acc && !busy) begin
                if (sel_ph) begin
                    ptr_high_r <= pwdata[7:0];
                end
                if (sel_pl) begin
                    ptr_low_r <= pwdata[7:0];
                end
            end
        end
    end

    // Data registers: read result lands at completion
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            data_high_r <= RST_BYTE;
            data_low_r  <= RST_BYTE;
        end else begin
            if (op_done && state_r == ST_READ) begin
                if (mode_eprom) begin
                    {data_high_r, data_low_r} <= eprom_rdata;
                end else begin
                    {data_high_r, data_low_r} <= otp_rdata;
                end
            end else if (wr_acc && !busy) begin
                if (sel_dh) begin
                    data_high_r <= pwdata[7:0];
                end
                if (sel_dl) begin
                    data_low_r <= pwdata[7:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Array side; addresses stay steady because the pointer is frozen
    assign eprom_addr  = ptr_low_r[5:0];
    assign otp_addr    = {ptr_high_r[2:0], ptr_low_r};
    assign eprom_wdata = {data_high_r, data_low_r};
    assign eprom_we    = (state_r == ST_WRITE);
    assign eprom_re    = (state_r == ST_READ) && mode_eprom;
    assign otp_re      = (state_r == ST_READ) && !mode_eprom;

    ////////////////////////////////////////////////////////////////////////
    // Check helpers: cycles spent in the running operation, counted apart
    // from cnt_r so that a broken down-counter cannot vouch for itself
    logic [CNT_W-1:0] op_len_r;
    logic             wr_req;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            op_len_r <= '0;
        end else if (!busy) begin
            op_len_r <= '0;
        end else begin
            op_len_r <= op_len_r + 1'b1;
        end
    end

    // Any software write that asks for a word write, accepted or not
    assign wr_req = wr_acc && sel_ctl && pwdata[BIT_WRITE];

    ////////////////////////////////////////////////////////////////////////
    // Checks: acceptance and refusal of commands
    write_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        start_wr |-> vpp_present && mode_eprom && ptr_low_r <= 8'h3f)
        else $error("write accepted without supply or in range pointer");

    write_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        start_wr |=> write_cmd_r && eprom_we && !eprom_re && !otp_re)
        else $error("accepted write did not start the array write");

    read_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        start_rd |=> read_cmd_r && !eprom_we && (eprom_re != otp_re))
        else $error("accepted read did not start exactly one array read");

    idle_no_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!busy && !start_wr && !start_rd) |=> !write_cmd_r && !read_cmd_r)
        else $error("command bit rose without a request");

    // A refused request must leave no trace: no bit, no strobe
    refuse_high_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (wr_req && !busy && ptr_low_r > MAX_POINTER) |=> !write_cmd_r && !eprom_we)
        else $error("write above top word was not refused");

    refuse_supply_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (wr_req && !busy && !vpp_present) |=> !write_cmd_r && !eprom_we)
        else $error("write without supply was not refused");

    refuse_mode_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (wr_req && !busy && !ptr_high_r[BIT_MODE]) |=> !write_cmd_r && !eprom_we)
        else $error("write in read-only mode was not refused");

    one_op_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        busy |-> !start_wr && !start_rd)
        else $error("command accepted while busy");

    cmd_pending_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        busy == (write_cmd_r || read_cmd_r))
        else $error("pending bits disagree with sequencer");

    single_pend_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !(write_cmd_r && read_cmd_r))
        else $error("both command bits pending");

    // Checks: completion, timing and pointer step
    write_done_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (op_done && state_r == ST_WRITE) |=> !write_cmd_r && ptr_low_r == $past(ptr_inc))
        else $error("write completion did not clear bit or step pointer");

    wr_stand_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (state_r == ST_WRITE && !op_done) |=> write_cmd_r && eprom_we)
        else $error("write bit or strobe dropped early");

    write_len_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (op_done && state_r == ST_WRITE) |-> op_len_r == CNT_W'(WRITE_CNT - 1))
        else $error("write did not last its programmed time");

    read_done_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (op_done && state_r == ST_READ && mode_eprom)
        |=> !read_cmd_r && {data_high_r, data_low_r} == $past(eprom_rdata))
        else $error("read completion did not load data or clear bit");

    rd_stand_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (state_r == ST_READ && !op_done) |=> read_cmd_r)
        else $error("read bit cleared before data arrived");

    // Read takes eight clocks at the nominal rate, within the repeat limit
    read_len_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        start_rd |=> read_cmd_r [*8] ##1 !read_cmd_r)
        else $error("read did not finish in expected cycles");

    read_time_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (op_done && state_r == ST_READ) |-> op_len_r == CNT_W'(READ_CYCLES - 1))
        else $error("read did not last its access time");

    otp_load_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (op_done && state_r == ST_READ && !mode_eprom)
        |=> {data_high_r, data_low_r} == $past(otp_rdata))
        else $error("read-only store word not loaded");

    ptr_sat_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        op_done |=> ptr_low_r <= 8'h3f)
        else $error("pointer step passed top word");

    ptr_step_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (op_done && ptr_low_r < MAX_POINTER) |=> ptr_low_r == $past(ptr_low_r) + 8'h01)
        else $error("pointer did not step by one");

    // Checks: held state and array side
    ptr_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (busy && !op_done) |=> $stable(ptr_low_r) && $stable(ptr_high_r))
        else $error("pointer moved during operation");

    data_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (busy && !op_done) |=> $stable(data_high_r) && $stable(data_low_r))
        else $error("data registers moved during operation");

    ph_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !(wr_acc && sel_ph && !busy) |=> $stable(ptr_high_r))
        else $error("pointer high changed without a software write");

    pl_load_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (wr_acc && sel_pl && !busy) |=> ptr_low_r == 8'($past(pwdata)))
        else $error("pointer low write did not land");

    word_addr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        eprom_we |-> ptr_low_r <= MAX_POINTER && eprom_addr == ptr_low_r[5:0])
        else $error("array write outside the word range");

    write_mode_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        eprom_we |-> ptr_high_r[BIT_MODE])
        else $error("array write outside array mode");

    write_word_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        start_wr |=> eprom_wdata == {$past(data_high_r), $past(data_low_r)})
        else $error("written word differs from data registers");

    mode_route_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (state_r == ST_READ) |-> eprom_re == ptr_high_r[BIT_MODE]
                                 && otp_re == !ptr_high_r[BIT_MODE])
        else $error("read routed to the wrong store");

    idle_quiet_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!write_cmd_r && !read_cmd_r) |-> !eprom_we && !eprom_re && !otp_re)
        else $error("array strobe without a pending command");

    otp_addr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        otp_re |-> otp_addr[10:8] == ptr_high_r[2:0] && otp_addr[7:0] == ptr_low_r)
        else $error("otp address mismatch");

    // Checks: what software sees when polling
    vpp_view_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (psel && sel_ctl) |-> prdata[2] == vpp_present)
        else $error("supply status misreported");

    ctl_view_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        sel_ctl |-> prdata[BIT_WRITE] == write_cmd_r && prdata[BIT_READ] == read_cmd_r)
        else $error("command bits misreported");
endmodule : eprom_word_access

// *** logic/eprom_word_access_pkg.sv ***
// Package: register map, field positions, reset values and timing for the EPROM word access block
package eprom_word_access_pkg;
    // Offsets are not all multiples of four: keep them as indices, byte address is index * 4
    localparam logic [9:0] IDX_CONTROL      = 10'h01c;
    localparam logic [9:0] IDX_POINTER_HIGH = 10'h01d;
    localparam logic [9:0] IDX_POINTER_LOW  = 10'h01e;
    localparam logic [9:0] IDX_DATA_HIGH    = 10'h01f;
    localparam logic [9:0] IDX_DATA_LOW     = 10'h020;
    localparam logic [9:0] IDX_CONTROL_ALT      = 10'h195;
    localparam logic [9:0] IDX_POINTER_HIGH_ALT = 10'h196;
    localparam logic [9:0] IDX_POINTER_LOW_ALT  = 10'h197;
    localparam logic [9:0] IDX_DATA_HIGH_ALT    = 10'h198;
    localparam logic [9:0] IDX_DATA_LOW_ALT     = 10'h199;
    localparam int         ADDR_W           = 12;

    // Control register fields
    localparam int BIT_VPP   = 2;
    localparam int BIT_WRITE = 1;
    localparam int BIT_READ  = 0;
    // Pointer high fields
    localparam int BIT_MODE  = 7;

    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic [5:0] MAX_WORD      = 6'h3f;
    localparam logic [7:0] MAX_POINTER   = 8'h3f;

    // Array access times
    localparam int CLK_MHZ        = 40;
    localparam int READ_TIME_NS   = 200;
    localparam int WRITE_TIME_US  = 100;
    localparam int READ_CYCLES    = (READ_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int WRITE_CYCLES   = WRITE_TIME_US * CLK_MHZ;
    localparam int CNT_W          = 13;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b10
    } op_state_t;
endpackage : eprom_word_access_pkg

// *** sim/eprom_array_model.sv ***
// Behavioural EPROM array and OTP store facing the access controller
`timescale 1ns/1ps
module eprom_array_model (
    input  wire logic        sys_clk,
    input  wire logic [5:0]  eprom_addr,
    input  wire logic [15:0] eprom_wdata,
    input  wire logic        eprom_we,
    input  wire logic        eprom_re,
    output logic      [15:0] eprom_rdata,
    input  wire logic [10:0] otp_addr,
    input  wire logic        otp_re,
    output logic      [15:0] otp_rdata
);
    logic [15:0] mem [64];
    logic [15:0] junk_r = 16'h5a5a;
    ////////////////////////////////////////////////////////////////////////////////
    // Blank cells read all ones, like an unprogrammed array
    initial begin
        foreach (mem[i]) mem[i] = 16'hffff;
    end
    // Word lands only while the write strobe is up; noise shifts every cycle
    always @(posedge sys_clk) begin
        if (eprom_we) begin
            mem[eprom_addr] <= eprom_wdata;
        end
        junk_r <= {junk_r[14:0], ~junk_r[15]};
    end
    // Undriven reads show noise so stale data cannot pass for a match
    assign eprom_rdata = eprom_re ? mem[eprom_addr] : junk_r;
    assign otp_rdata   = otp_re ? ({5'h00, otp_addr} ^ 16'hc3c3) : ~junk_r;
endmodule : eprom_array_model

// *** sim/eprom_word_access_tb.sv ***
// Self-checking bench for the EPROM word access controller
`timescale 1ns/1ps
module eprom_word_access_tb;
    import eprom_word_access_pkg::*;
    logic              sys_clk, rstn, psel, penable, pwrite, pready, pslverr;
    logic              vpp_present, eprom_we, eprom_re, otp_re, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata;
    logic [5:0]        eprom_addr;
    logic [15:0]       eprom_wdata, eprom_rdata, otp_rdata;
    logic [10:0]       otp_addr;
    logic [7:0]        rd;
    int                failures, checked;

    // Short write count keeps the run brief and leaves room to poke mid-write
    eprom_word_access #(.WRITE_CNT(20)) i_eprom_word_access (.sys_clk(sys_clk), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .vpp_present(vpp_present),
        .eprom_addr(eprom_addr), .eprom_wdata(eprom_wdata), .eprom_we(eprom_we),
        .eprom_re(eprom_re), .eprom_rdata(eprom_rdata), .otp_addr(otp_addr),
        .otp_re(otp_re), .otp_rdata(otp_rdata));
    eprom_array_model i_eprom_array_model (.sys_clk(sys_clk), .eprom_addr(eprom_addr),
        .eprom_wdata(eprom_wdata), .eprom_we(eprom_we), .eprom_re(eprom_re),
        .eprom_rdata(eprom_rdata), .otp_addr(otp_addr), .otp_re(otp_re),
        .otp_rdata(otp_rdata));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h00_0000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        // No own limit: only the watchdog may end a wait for the answer
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd  = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic rdchk(input logic [9:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk({8'h00, rd}, {8'h00, exp});
    endtask : rdchk
    // Bounded poll; a bit stuck high shows up as a mismatch
    task automatic poll(input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, IDX_CONTROL, 8'h00);
            n++;
        end while (rd[b] !== 1'b0 && n < 100);
        chk({15'h0000, rd[b]}, 16'h0000);
    endtask : poll
    task automatic rdword(input logic [7:0] p, input logic [15:0] exp);
        apb(1'b1, IDX_POINTER_LOW, p);
        apb(1'b1, IDX_CONTROL, 8'h01);
        poll(BIT_READ);
        rdchk(IDX_DATA_HIGH_ALT, exp[15:8]);
        rdchk(IDX_DATA_LOW, exp[7:0]);
    endtask : rdword
    task automatic final_report;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [9:0] regs [5] = '{IDX_CONTROL, IDX_POINTER_HIGH, IDX_POINTER_LOW,
                                 IDX_DATA_HIGH, IDX_DATA_LOW};
        foreach (regs[i]) rdchk(regs[i], 8'h00);
        apb(1'b0, 10'h021, 8'h00);
        chk({15'h0000, err}, 16'h0001);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_vpp;
        vpp_present <= 1'b1;
        rdchk(IDX_CONTROL, 8'h04);
        apb(1'b1, IDX_CONTROL_ALT, 8'h00);
        rdchk(IDX_CONTROL, 8'h04);
        $display("t_vpp done");
    endtask : t_vpp
    // Write next to the top word, then at it, then read both back
    task automatic t_write_read;
        apb(1'b1, IDX_POINTER_HIGH, 8'h80);
        apb(1'b1, IDX_POINTER_LOW, 8'h3e);
        apb(1'b1, IDX_DATA_HIGH, 8'h12);
        apb(1'b1, IDX_DATA_LOW, 8'h34);
        // Supply was raised in t_vpp, so vpp_present is high and this write is accepted
        apb(1'b1, IDX_CONTROL, 8'h02);
        poll(BIT_WRITE);
        rdchk(IDX_POINTER_LOW, 8'h3f);
        apb(1'b1, IDX_DATA_HIGH, 8'hab);
        apb(1'b1, IDX_DATA_LOW, 8'hcd);
        apb(1'b1, IDX_CONTROL, 8'h02);
        poll(BIT_WRITE);
        rdchk(IDX_POINTER_LOW_ALT, 8'h3f);
        apb(1'b1, IDX_DATA_HIGH, 8'h00);
        rdword(8'h3e, 16'h1234);
        rdchk(IDX_POINTER_LOW, 8'h3f);
        rdword(8'h3f, 16'habcd);
        rdchk(IDX_POINTER_LOW, 8'h3f);
        $display("t_write_read done");
    endtask : t_write_read
    // Pointer too high, no supply, OTP mode: each write refused
    task automatic t_refuse;
        apb(1'b1, IDX_POINTER_LOW, 8'h40);
        apb(1'b1, IDX_CONTROL, 8'h02);
        rdchk(IDX_CONTROL, 8'h04);
        rdchk(IDX_POINTER_LOW, 8'h40);
        rdword(8'h00, 16'hffff);
        vpp_present <= 1'b0;
        apb(1'b1, IDX_CONTROL, 8'h02);
        rdchk(IDX_CONTROL, 8'h00);
        vpp_present <= 1'b1;
        apb(1'b1, IDX_POINTER_HIGH, 8'h05);
        apb(1'b1, IDX_CONTROL, 8'h02);
        rdchk(IDX_CONTROL, 8'h04);
        rdword(8'h9a, 16'h059a ^ 16'hc3c3);
        $display("t_refuse done");
    endtask : t_refuse
    // Pokes during a write must not disturb it
    task automatic t_busy;
        apb(1'b1, IDX_POINTER_HIGH, 8'h80);
        apb(1'b1, IDX_POINTER_LOW, 8'h10);
        apb(1'b1, IDX_DATA_HIGH, 8'h77);
        apb(1'b1, IDX_DATA_LOW, 8'h88);
        apb(1'b1, IDX_CONTROL, 8'h02);
        apb(1'b1, IDX_POINTER_LOW, 8'h20);
        apb(1'b1, IDX_DATA_HIGH, 8'hee);
        apb(1'b1, IDX_CONTROL, 8'h01);
        poll(BIT_WRITE);
        chk({15'h0000, rd[BIT_READ]}, 16'h0000);
        rdchk(IDX_POINTER_LOW, 8'h11);
        rdchk(IDX_DATA_HIGH, 8'h77);
        rdword(8'h10, 16'h7788);
        $display("t_busy done");
    endtask : t_busy
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Far beyond the few hundred cycles the tests take
    initial begin
        #(25 * 20000);
        failures++;
        final_report();
    end
    initial begin
        {rstn, psel, penable, pwrite, vpp_present} = 5'h00;
        paddr  = '0;
        pwdata = '0;
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_vpp();
        t_write_read();
        t_refuse();
        t_busy();
        final_report();
    end
endmodule : eprom_word_access_tb
